// ==== csu_bank.sv ====
/*
 * Calibration/setup register bank with its two-wire serial slave and the
 * three-address unlock detector that gates access to bank 2.
 * Assumes an open-drain bus with external pull-ups, and a static
 * nonvolatile image presented on nv_image_in from power-up on.
 */
`timescale 1ns/1ps
module csu_bank
   import csu_pkg::*;
#(
   // Silicon revision reported in the clock test register; value arbitrary
   parameter logic [REV_WIDTH-1:0] REVISION = 5'h01
)
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // Serial pins, data is open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Nonvolatile image of bank 2, byte k at bits 8k+7..8k
   input wire logic [8*NUM_REGS-1:0] nv_image_in,
   // Setup state and register contents
   output logic setup_mode_out,
   output logic [7:0] bus_slave_address_out,
   output logic [7:0] bandgap_trim_out,
   output logic [7:0] reference_trim_out,
   output logic [7:0] main_osc_trim_out,
   output logic [7:0] clock_test_control_out,
   output logic [7:0] test_mux_select_out,
   output logic [7:0] aux_osc_trim_out
);

   // ****************************************************************
   // Pin conditioning and bus events
   // ****************************************************************
   logic scl_s, sda_s;
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, start_det, stop_det;

   csu_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync
   (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .d_in({scl_in, sda_in}),
      .q_out({scl_s, sda_s})
   );

   // Previous synchronised levels for edge detection
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // Start and stop are data edges while the clock stays high
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

   // ****************************************************************
   // Register bank storage
   // ****************************************************************
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] regs_d [NUM_REGS];
   logic init_done_q, init_done_d;
   logic bank_we;
   logic [7:0] bank_wdata;
   logic [7:0] ptr_q, ptr_d;
   logic setup_q, setup_d;
   logic [7:0] reg_view [NUM_REGS];
   logic [7:0] rd_byte;

   // Readable view: revision is wired in, reserved bits already zero
   always_comb
   begin
      for (int i = 0; i < NUM_REGS; i++)
         reg_view[i] = regs_q[i];
      reg_view[4][REV_LSB +: REV_WIDTH] = REVISION;
      rd_byte = 8'h00;
      if (setup_q && in_bank2(ptr_q))
         rd_byte = reg_view[ptr_q[2:0]];
   end

   // First cycle after reset copies the image; later only serial writes
   always_comb
   begin
      init_done_d = 1'b1;
      for (int i = 0; i < NUM_REGS; i++)
         regs_d[i] = regs_q[i];
      if (!init_done_q)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            regs_d[i] = nv_image_in[8*i +: 8] & REG_MASK[i];
      end
      else if (bank_we)
         regs_d[ptr_q[2:0]] = bank_wdata & REG_MASK[ptr_q[2:0]];
   end

   // Async reset holds factory defaults until the image arrives
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         init_done_q <= 1'b0;
         for (int i = 0; i < NUM_REGS; i++)
            regs_q[i] <= REG_RESET[i];
      end
      else
      begin
         init_done_q <= init_done_d;
         for (int i = 0; i < NUM_REGS; i++)
            regs_q[i] <= regs_d[i];
      end
   end

   // ****************************************************************
   // Serial engine and unlock detector
   // ****************************************************************
   csu_state_e state_q, state_d;
   logic [2:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] shift_q, shift_d;
   logic ptr_set_q, ptr_set_d;
   logic rd_q, rd_d;
   logic ack_q, ack_d;
   logic sda_oe_q, sda_oe_d;
   logic [1:0] seq_idx_q, seq_idx_d;
   logic [7:0] in_byte;
   logic byte_done;

   assign in_byte = {shift_q[6:0], sda_s};
   assign byte_done = scl_rise && (bit_cnt_q == 3'h7);

   // Next state; start and stop override every state
   always_comb
   begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      ptr_set_d = ptr_set_q;
      rd_d = rd_q;
      ack_d = ack_q;
      sda_oe_d = sda_oe_q;
      seq_idx_d = seq_idx_q;
      setup_d = setup_q;
      bank_we = 1'b0;
      bank_wdata = in_byte;
      if (start_det)
      begin
         // Repeated start keeps the unlock count running
         state_d = ST_ADDR;
         bit_cnt_d = 3'h0;
         sda_oe_d = 1'b0;
         ptr_set_d = 1'b0;
      end
      else if (stop_det)
      begin
         state_d = ST_IDLE;
         sda_oe_d = 1'b0;
         seq_idx_d = 2'h0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               sda_oe_d = 1'b0;
            end
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  shift_d = in_byte;
                  bit_cnt_d = bit_cnt_q + 3'h1;
               end
               if (byte_done)
               begin
                  state_d = ST_ADDR_ACK;
                  rd_d = in_byte[0];
                  // Own address, unless it is one of the unlock bytes
                  ack_d = !is_unlock(in_byte) &&
                          (in_byte[7:1] == regs_q[0][7:1]);
                  if (in_byte == unlock_addr(seq_idx_q))
                  begin
                     if (seq_idx_q == UNLOCK_LAST_STEP)
                     begin
                        setup_d = !setup_q;
                        seq_idx_d = 2'h0;
                     end
                     else
                        seq_idx_d = seq_idx_q + 2'h1;
                  end
                  else if (in_byte == UNLOCK_ADDR_0)
                     seq_idx_d = 2'h1;
                  else
                     seq_idx_d = 2'h0;
               end
            end
            ST_ADDR_ACK, ST_WRITE_ACK:
            begin
               if (scl_fall && bit_cnt_q == 3'h0)
               begin
                  // Refused byte: release and wait for the next start
                  sda_oe_d = ack_q;
                  bit_cnt_d = 3'h1;
                  if (!ack_q)
                     state_d = ST_IDLE;
               end
               else if (scl_fall)
               begin
                  bit_cnt_d = 3'h0;
                  sda_oe_d = 1'b0;
                  state_d = ST_WRITE;
                  seq_idx_d = 2'h0;
                  if (state_q == ST_ADDR_ACK && rd_q)
                  begin
                     state_d = ST_READ;
                     shift_d = rd_byte;
                     sda_oe_d = !rd_byte[7];
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            end
            ST_WRITE:
            begin
               if (scl_rise)
               begin
                  shift_d = in_byte;
                  bit_cnt_d = bit_cnt_q + 3'h1;
               end
               if (byte_done)
               begin
                  state_d = ST_WRITE_ACK;
                  ack_d = 1'b1;
                  if (!ptr_set_q)
                  begin
                     ptr_d = in_byte;
                     ptr_set_d = 1'b1;
                  end
                  else
                  begin
                     // Protected bytes are refused outside setup mode
                     ack_d = setup_q && in_bank2(ptr_q);
                     bank_we = ack_d;
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            end
            ST_READ:
            begin
               if (scl_fall && bit_cnt_q == 3'h7)
               begin
                  sda_oe_d = 1'b0;
                  bit_cnt_d = 3'h0;
                  state_d = ST_READ_ACK;
               end
               else if (scl_fall)
               begin
                  shift_d = {shift_q[6:0], 1'b0};
                  sda_oe_d = !shift_q[6];
                  bit_cnt_d = bit_cnt_q + 3'h1;
               end
            end
            ST_READ_ACK:
            begin
               // Host not-acknowledge ends the read
               if (scl_rise && sda_s)
                  state_d = ST_IDLE;
               else if (scl_fall)
               begin
                  state_d = ST_READ;
                  shift_d = rd_byte;
                  sda_oe_d = !rd_byte[7];
                  ptr_d = ptr_q + 8'h01;
               end
            end
            default:
            begin
               state_d = ST_IDLE;
               sda_oe_d = 1'b0;
            end
         endcase
      end
   end

   // Setup mode is volatile: every reset starts it inactive
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 3'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         ptr_set_q <= 1'b0;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
         seq_idx_q <= 2'h0;
         setup_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         ptr_set_q <= ptr_set_d;
         rd_q <= rd_d;
         ack_q <= ack_d;
         sda_oe_q <= sda_oe_d;
         seq_idx_q <= seq_idx_d;
         setup_q <= setup_d;
      end
   end

   // Outputs straight from flops; the data pin only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_q;
   assign setup_mode_out = setup_q;
   assign bus_slave_address_out = regs_q[0];
   assign bandgap_trim_out = regs_q[1];
   assign reference_trim_out = regs_q[2];
   assign main_osc_trim_out = regs_q[3];
   assign clock_test_control_out = regs_q[4];
   assign test_mux_select_out = regs_q[5];
   assign aux_osc_trim_out = regs_q[6];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   logic addr_done;
   assign addr_done = (state_q == ST_ADDR) && byte_done;

   sequence s_third_addr;
      addr_done && in_byte == UNLOCK_ADDR_2 &&
         seq_idx_q == UNLOCK_LAST_STEP;
   endsequence

   property p_unlock_nack;
      addr_done && is_unlock(in_byte) |=> !ack_q ##1 !sda_oe_q[*2];
   endproperty
   a_unlock_nack: assert property (p_unlock_nack)
      else $error("unlock address was acknowledged");

   property p_enter_setup;
      s_third_addr ##0 !setup_q |=> setup_q && seq_idx_q == 2'h0;
   endproperty
   a_enter_setup: assert property (p_enter_setup)
      else $error("setup not entered after full sequence");

   property p_leave_setup;
      s_third_addr ##0 setup_q |=> !setup_q;
   endproperty
   a_leave_setup: assert property (p_leave_setup)
      else $error("setup not left after repeated sequence");

   property p_setup_only_by_seq;
      !(addr_done && in_byte == UNLOCK_ADDR_2) |=> $stable(setup_q);
   endproperty
   a_setup_only_by_seq: assert property (p_setup_only_by_seq)
      else $error("setup changed without the sequence");

   property p_power_up_off;
      !init_done_q |-> !setup_q && regs_q[0] == RST_BUS_SLAVE_ADDRESS;
   endproperty
   a_power_up_off: assert property (p_power_up_off)
      else $error("setup active or address wrong at power-up");

   property p_write_gated;
      bank_we |-> setup_q && in_bank2(ptr_q) && state_q == ST_WRITE;
   endproperty
   a_write_gated: assert property (p_write_gated)
      else $error("bank 2 written outside setup mode");

   property p_addr_write;
      bank_we && ptr_q == OFS_BUS_SLAVE_ADDRESS |=>
         regs_q[0] == {$past(in_byte[7:1]), 1'b0} ##1 ack_q;
   endproperty
   a_addr_write: assert property (p_addr_write)
      else $error("bus address write lost");

   // Own address byte, then the fall that opens its ack slot
   sequence s_own_addr;
      addr_done && !is_unlock(in_byte) &&
         in_byte[7:1] == regs_q[0][7:1];
   endsequence

   sequence s_ack_slot;
      state_q == ST_ADDR_ACK && ack_q && scl_fall && bit_cnt_q == 3'h0;
   endsequence

   property p_own_ack;
      s_own_addr |=> ack_q && state_q == ST_ADDR_ACK;
   endproperty
   a_own_ack: assert property (p_own_ack)
      else $error("own address not acknowledged");

   property p_ack_drive;
      s_ack_slot |=> sda_oe_q;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("ack slot not driven low");

   property p_bandgap_field;
      init_done_q |-> regs_q[1][7:4] == 4'h0 && regs_q[0][0] == 1'b0;
   endproperty
   a_bandgap_field: assert property (p_bandgap_field)
      else $error("reserved bits of bank 2 not zero");

   property p_image_load;
      !init_done_q |=> regs_q[3] == ($past(nv_image_in[31:24]) &
         MSK_MAIN_OSC_TRIM) && init_done_q;
   endproperty
   a_image_load: assert property (p_image_load)
      else $error("nonvolatile image not loaded");

   property p_stop_restarts;
      stop_det |=> seq_idx_q == 2'h0 && state_q == ST_IDLE;
   endproperty
   a_stop_restarts: assert property (p_stop_restarts)
      else $error("stop did not restart unlock count");

endmodule : csu_bank

// ==== csu_pkg.sv ====
/*
 * Constants, types and helper functions for the calibration/setup unlock
 * bank of a battery fuel gauge: register offsets, reset values, field
 * masks, the unlock address sequence and the serial engine states.
 * Assumes the compiler sees this package before any module that imports it.
 */
// Behaviour
// - Unlock needs 0x50, 0x52, 0x74 back to back
// - Each unlock address is not acknowledged
// - Third unlock address enters setup, opens bank 2
// - Same sequence again leaves setup; power loss too
// - Setup mode is always off after power-up
// - Bank 2 reachable only while in setup mode
// - Setup lets host rewrite address and all trims
// - Slave address in bits 7..1 at 0x80, used
// - Bandgap trim is four low bits, nominal 0111
// - Power-on loads bank 2 from nonvolatile image
// - Factory image answers on address byte 0x26
package csu_pkg;

   // ****************************************************************
   // Register map of bank 2
   // ****************************************************************
   localparam int NUM_REGS = 8;
   localparam logic [7:0] OFS_BUS_SLAVE_ADDRESS = 8'h80;
   localparam logic [7:0] OFS_BANDGAP_TRIM = 8'h81;
   localparam logic [7:0] OFS_REFERENCE_TRIM = 8'h82;
   localparam logic [7:0] OFS_MAIN_OSC_TRIM = 8'h83;
   localparam logic [7:0] OFS_CLOCK_TEST_CONTROL = 8'h84;
   localparam logic [7:0] OFS_TEST_MUX_SELECT = 8'h85;
   localparam logic [7:0] OFS_AUX_OSC_TRIM = 8'h86;
   localparam logic [7:0] OFS_BANK2_LAST = 8'h87;

   // Reset values, seen only until the nonvolatile image is loaded
   localparam logic [7:0] RST_BUS_SLAVE_ADDRESS = 8'h26;
   localparam logic [7:0] RST_BANDGAP_TRIM = 8'h07;
   localparam logic [7:0] RST_REFERENCE_TRIM = 8'h1F;
   localparam logic [7:0] RST_MAIN_OSC_TRIM = 8'h3F;
   localparam logic [7:0] RST_CLOCK_TEST_CONTROL = 8'h00;
   localparam logic [7:0] RST_TEST_MUX_SELECT = 8'h00;
   localparam logic [7:0] RST_AUX_OSC_TRIM = 8'h10;
   localparam logic [7:0] RST_RESERVED = 8'h00;

   // Writable bits of each register; reserved bits store and read zero
   localparam logic [7:0] MSK_BUS_SLAVE_ADDRESS = 8'hFE;
   localparam logic [7:0] MSK_BANDGAP_TRIM = 8'h0F;
   localparam logic [7:0] MSK_REFERENCE_TRIM = 8'hFF;
   localparam logic [7:0] MSK_MAIN_OSC_TRIM = 8'h7F;
   localparam logic [7:0] MSK_CLOCK_TEST_CONTROL = 8'h07;
   localparam logic [7:0] MSK_TEST_MUX_SELECT = 8'hFF;
   localparam logic [7:0] MSK_AUX_OSC_TRIM = 8'h1F;
   localparam logic [7:0] MSK_RESERVED = 8'h00;

   // Read-only revision field of the clock test register
   localparam int REV_LSB = 3;
   localparam int REV_WIDTH = 5;

   localparam logic [7:0] REG_RESET [NUM_REGS] = '{
      RST_BUS_SLAVE_ADDRESS, RST_BANDGAP_TRIM, RST_REFERENCE_TRIM,
      RST_MAIN_OSC_TRIM, RST_CLOCK_TEST_CONTROL, RST_TEST_MUX_SELECT,
      RST_AUX_OSC_TRIM, RST_RESERVED};
   localparam logic [7:0] REG_MASK [NUM_REGS] = '{
      MSK_BUS_SLAVE_ADDRESS, MSK_BANDGAP_TRIM, MSK_REFERENCE_TRIM,
      MSK_MAIN_OSC_TRIM, MSK_CLOCK_TEST_CONTROL, MSK_TEST_MUX_SELECT,
      MSK_AUX_OSC_TRIM, MSK_RESERVED};

   // ****************************************************************
   // Unlock sequence, whole address bytes including direction bit
   // ****************************************************************
   localparam logic [7:0] UNLOCK_ADDR_0 = 8'h50;
   localparam logic [7:0] UNLOCK_ADDR_1 = 8'h52;
   localparam logic [7:0] UNLOCK_ADDR_2 = 8'h74;
   localparam logic [1:0] UNLOCK_LAST_STEP = 2'h2;

   // ****************************************************************
   // Serial engine states, Gray along the usual path
   // ****************************************************************
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ADDR_ACK = 3'h3,
      ST_WRITE = 3'h2,
      ST_WRITE_ACK = 3'h6,
      ST_READ = 3'h7,
      ST_READ_ACK = 3'h5
   } csu_state_e;

   // Expected address byte for a given unlock step
   function automatic logic [7:0] unlock_addr(input logic [1:0] step);
      unique case (step)
         2'h0: unlock_addr = UNLOCK_ADDR_0;
         2'h1: unlock_addr = UNLOCK_ADDR_1;
         default: unlock_addr = UNLOCK_ADDR_2;
      endcase
   endfunction : unlock_addr

   // True for any of the three unlock address bytes
   function automatic logic is_unlock(input logic [7:0] b);
      is_unlock = (b == UNLOCK_ADDR_0) || (b == UNLOCK_ADDR_1) ||
                  (b == UNLOCK_ADDR_2);
   endfunction : is_unlock

   // True when a register pointer falls inside bank 2
   function automatic logic in_bank2(input logic [7:0] p);
      in_bank2 = (p >= OFS_BUS_SLAVE_ADDRESS) && (p <= OFS_BANK2_LAST);
   endfunction : in_bank2

endpackage : csu_pkg

// ==== csu_sync.sv ====
/*
 * Two-flop synchroniser for the serial pins.
 * Assumes the pins are asynchronous to mclk_in; idle level is the reset.
 */
`timescale 1ns/1ps
module csu_sync
   import csu_pkg::*;
#(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
)
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // Raw and synchronised levels
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         meta_q <= RESET_VAL;
         q_out <= RESET_VAL;
      end
      else
      begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end

endmodule : csu_sync

// ==== csu_host.sv ====
/*
 * Host model: a bit-level two-wire bus master for the setup bank.
 * Assumes the bench resolves the open-drain data wire with a pull-up
 * and feeds the resolved level back on sda_in.
 */
`timescale 1ns/1ps
module csu_host
#(
   parameter int PH = 6
)
(
   // Clock
   input wire logic mclk_in,
   // Pins
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out,
   // Observed results, one-cycle strobe
   output logic res_stb_out,
   output logic [7:0] res_out
);

   // Idle bus: both lines released
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
      res_stb_out = 1'b0;
      res_out = 8'h00;
   end

   // Move just after an edge; phases stay well above the 4-cycle floor
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : tick

   // Hand one result to the bench for a single cycle
   task automatic post(input logic [7:0] v);
      res_out = v;
      res_stb_out = 1'b1;
      tick(1);
      res_stb_out = 1'b0;
   endtask : post

   // Data set in the low phase, sampled at the end of the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_low_out = ~b;
      tick(PH);
      scl_out = 1'b1;
      tick(PH);
      r = sda_in;
      scl_out = 1'b0;
   endtask : bit_io

   // Start, also usable as a repeated start from a low clock
   task automatic start;
      sda_low_out = 1'b0;
      tick(PH);
      scl_out = 1'b1;
      tick(PH);
      sda_low_out = 1'b1;
      tick(PH);
      scl_out = 1'b0;
   endtask : start

   // Stop, leaves the bus idle
   task automatic stop;
      sda_low_out = 1'b1;
      tick(PH);
      scl_out = 1'b1;
      tick(PH);
      sda_low_out = 1'b0;
      tick(PH);
   endtask : stop

   // Byte out MSB first; reports 01 for ack, 00 for nack
   task automatic tx(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      post({7'h00, ~r});
   endtask : tx

   // Byte in; host nacks the last one so the device lets go
   task automatic rx(input logic last);
      logic r;
      logic [7:0] d;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
      post(d);
   endtask : rx

   // Three unlock bytes joined by repeated starts, nothing between
   task automatic unlock;
      start;
      tx(8'h50);
      start;
      tx(8'h52);
      start;
      tx(8'h74);
      stop;
   endtask : unlock

endmodule : csu_host

// ==== csu_bank_test.sv ====
/*
 * Self-checking bench for the setup bank: unlock, access gating,
 * register writes and reads, relock and reset reload.
 * Assumes csu_pkg is compiled first and csu_host drives the bus.
 */
`timescale 1ns/1ps
module csu_bank_test
   import csu_pkg::*;
;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [63:0] nv;
   logic scl, host_low, sda, oe, sda_o, setup, res_stb;
   logic [7:0] res;
   logic [7:0] regs [7];
   logic [7:0] exp_r [7];
   logic [7:0] wbuf [9];
   logic [7:0] exp_q [$];
   int n_errors = 0;
   int check_count = 0;

   // ******************************************************
   // Clock, wire and instances
   // ******************************************************
   always #10 mclk = ~mclk;
   // Open-drain data: low if either side pulls, else pull-up
   assign sda = ~(host_low | (oe & ~sda_o));

   csu_bank csu_bank_i (.mclk_in(mclk), .nrst_in(nrst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_o), .sda_oe_out(oe), .nv_image_in(nv),
      .setup_mode_out(setup), .bus_slave_address_out(regs[0]),
      .bandgap_trim_out(regs[1]), .reference_trim_out(regs[2]),
      .main_osc_trim_out(regs[3]), .clock_test_control_out(regs[4]),
      .test_mux_select_out(regs[5]), .aux_osc_trim_out(regs[6]));
   csu_host csu_host_i (.mclk_in(mclk), .sda_in(sda), .scl_out(scl),
      .sda_low_out(host_low), .res_stb_out(res_stb), .res_out(res));

   // ******************************************************
   // Checking helpers
   // ******************************************************
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic push(input logic [7:0] v);
      exp_q.push_back(v);
   endtask : push

   task automatic summarize;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize

   // Each bus result takes the oldest note off the queue
   always @(posedge mclk)
      if (res_stb === 1'b1)
      begin
         if (exp_q.size() == 0)
            cmp(res, 8'hXX);
         else
            cmp(res, exp_q.pop_front());
      end

   // Hang guard: a stuck run still ends in the report
   initial
   begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      $display("[ERR] %0t run timed out", $time);
      summarize;
   end

   task automatic chk_regs;
      for (int k = 0; k < 7; k++)
         cmp(regs[k], exp_r[k]);
   endtask : chk_regs

   // Reset for 12 cycles; the image is masked into the registers
   task automatic do_reset;
      nrst = 1'b0;
      repeat (12) @(posedge mclk);
      #1;
      nrst = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      for (int k = 0; k < 7; k++)
         exp_r[k] = nv[8*k +: 8] & REG_MASK[k];
   endtask : do_reset

   task automatic nack_tx(input logic [7:0] b);
      push(8'h00);
      csu_host_i.tx(b);
   endtask : nack_tx

   task automatic do_unlock;
      for (int i = 0; i < 3; i++)
         push(8'h00);
      csu_host_i.unlock;
   endtask : do_unlock

   // Write n bytes from wbuf at pointer p; the first nok are acked
   task automatic wr(input logic [7:0] a, input logic [7:0] p,
      input int n, input int nok);
      csu_host_i.start;
      push(8'h01);
      csu_host_i.tx(a);
      push(8'h01);
      csu_host_i.tx(p);
      for (int i = 0; i < n; i++)
      begin
         push({7'h00, i < nok});
         csu_host_i.tx(wbuf[i]);
      end
      csu_host_i.stop;
   endtask : wr

   // Set pointer, repeated start, read n bytes; locked reads give 00
   task automatic rd(input logic [7:0] a, input logic [7:0] p,
      input int n, input logic open);
      csu_host_i.start;
      push(8'h01);
      csu_host_i.tx(a);
      push(8'h01);
      csu_host_i.tx(p);
      csu_host_i.start;
      push(8'h01);
      csu_host_i.tx(a | 8'h01);
      for (int i = 0; i < n; i++)
      begin
         push(open ? exp_r[int'(p[2:0]) + i] : 8'h00);
         csu_host_i.rx(i == n - 1);
      end
      csu_host_i.stop;
   endtask : rd

   // ******************************************************
   // Main sequence
   // ******************************************************
   initial
   begin
      void'($urandom(32'h35B6EBD7));
      for (int k = 0; k < 8; k++)
         nv[8*k +: 8] = 8'($urandom());
      nv[7:0] = 8'h26;
      nv[63:32] = {8'h00, nv[55:48], 16'h0000};
      for (int k = 0; k < 9; k++)
         wbuf[k] = 8'($urandom());
      wbuf[0][7:4] = 4'h3;
      do_reset;
      chk_regs;
      cmp({7'h00, setup}, 8'h00);
      wr(8'h26, 8'h81, 1, 0);
      rd(8'h26, 8'h81, 1, 1'b0);
      chk_regs;
      // A stop between unlock bytes must spoil the sequence
      csu_host_i.start;
      nack_tx(8'h50);
      csu_host_i.stop;
      csu_host_i.start;
      nack_tx(8'h52);
      csu_host_i.start;
      nack_tx(8'h74);
      csu_host_i.stop;
      cmp({7'h00, setup}, 8'h00);
      do_unlock;
      cmp({7'h00, setup}, 8'h01);
      wr(8'h26, 8'h80, 9, 8);
      for (int k = 0; k < 7; k++)
         exp_r[k] = wbuf[k] & REG_MASK[k];
      chk_regs;
      csu_host_i.start;
      nack_tx(8'h26);
      csu_host_i.stop;
      rd(exp_r[0], 8'h81, 3, 1'b1);
      do_unlock;
      cmp({7'h00, setup}, 8'h00);
      rd(exp_r[0], 8'h81, 1, 1'b0);
      do_unlock;
      cmp({7'h00, setup}, 8'h01);
      do_reset;
      cmp({7'h00, setup}, 8'h00);
      chk_regs;
      rd(8'h26, 8'h80, 1, 1'b0);
      if (exp_q.size() != 0)
      begin
         n_errors++;
         $display("[ERR] %0t bus results missing", $time);
      end
      summarize;
   end

endmodule : csu_bank_test
